// File: hw/evt_pkg.sv
// Purpose: Shared constants, types and helpers of the two-stage event controller.
// Assumes: Sixteen core levels, thirty-two peripheral sources, byte addressed register map.
// Notes: Levels 4 to 6 are never raised by this design.
package evt_pkg;
  localparam int NUM_LVL = 16;
  localparam int NUM_SRC = 32;
  localparam int NUM_GP = 9;
  localparam int NUM_IAR = 4;
  localparam int IAR_W = 4;
  localparam int SRC_PER_IAR = 8;
  localparam logic [3:0] LVL_EMU = 4'h0;
  localparam logic [3:0] LVL_RST = 4'h1;
  localparam logic [3:0] LVL_NMI = 4'h2;
  localparam logic [3:0] LVL_EXC = 4'h3;
  localparam logic [3:0] LVL_GP0 = 4'h7;
  localparam logic [7:0] OFS_SMASK = 8'h00;
  localparam logic [7:0] OFS_SRAW = 8'h04;
  localparam logic [7:0] OFS_WAKE = 8'h08;
  localparam logic [7:0] OFS_WSTAT = 8'h0C;
  localparam logic [7:0] OFS_LSEL = 8'h10;
  localparam logic [7:0] OFS_LSTAT = 8'h14;
  localparam logic [7:0] OFS_IAR0 = 8'h20;
  localparam logic [7:0] OFS_CMASK = 8'h40;
  localparam logic [7:0] OFS_CPEND = 8'h44;
  localparam logic [7:0] OFS_CLAT = 8'h48;
  localparam logic [7:0] OFS_CRAISE = 8'h4C;
  localparam logic [7:0] OFS_ISTAT = 8'h50;
  localparam logic [7:0] OFS_IMASK = 8'h54;
  localparam logic [7:0] OFS_EVT0 = 8'h80;
  localparam logic [31:0] SMASK_RST = 32'h0000_0000;
  localparam logic [15:0] CMASK_RST = 16'h0000;
  localparam logic [15:0] FIXED_LVLS = 16'h000F;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  localparam logic [1:0] RESP_DECERR = 2'b11;
  localparam int ST_TAKEN = 0;
  localparam int ST_NMI = 1;
  localparam int ST_VIOL = 2;
  localparam int ST_EXC = 3;
  localparam int ST_W = 4;
  typedef enum logic [2:0] {
    CLS_EMU = 3'b000,
    CLS_RST = 3'b001,
    CLS_NMI = 3'b010,
    CLS_EXC = 3'b011,
    CLS_INT = 3'b100
  } class_type;
  typedef struct packed {
    logic valid;
    logic [3:0] level;
    logic [31:0] vector;
  } offer_type;
  typedef struct packed {
    logic valid;
    class_type cls;
  } ret_req_type;
  typedef struct packed {
    logic valid;
    logic [31:0] addr;
  } resume_type;
  function automatic class_type class_of(input logic [3:0] lvl);
    class_type c;
    c = CLS_INT;
    if (lvl <= LVL_EXC)
    begin
      c = class_type'({1'b0, lvl[1:0]});
    end
    return c;
  endfunction
  function automatic logic [4:0] lowest_set(input logic [15:0] v);
    logic [4:0] r;
    r = 5'h00;
    for (int i = NUM_LVL - 1; i >= 0; i--)
    begin
      if (v[i])
      begin
        r = {1'b1, 4'(i)};
      end
    end
    return r;
  endfunction
  function automatic logic [31:0] default_iar(input int n);
    logic [31:0] r;
    r = 32'h0000_0000;
    for (int k = 0; k < SRC_PER_IAR; k++)
    begin
      r[k*IAR_W +: IAR_W] = 4'((n * SRC_PER_IAR + k) % 7);
    end
    return r;
  endfunction
endpackage

// File: hw/system_interrupt_stage.sv
// Purpose: Routes peripheral requests onto the general-purpose core levels.
// Assumes: Assignment fields hold a level offset from the first general level.
// Notes: A field of nine or more parks its source on no level.
`timescale 1ns/1ps
`default_nettype none
module system_interrupt_stage #(
  parameter int NSRC = 32
) (
  input wire logic [NSRC-1:0] src,
  input wire logic [NSRC-1:0] enable,
  input wire logic [NSRC*evt_pkg::IAR_W-1:0] assign_map,
  output logic [evt_pkg::NUM_GP-1:0] gp_req
);
  import evt_pkg::*;
  always_comb
  begin
    gp_req = '0;
    for (int s = 0; s < NSRC; s++)
    begin
      for (int g = 0; g < NUM_GP; g++)
      begin
        if (src[s] && enable[s] && (assign_map[s*IAR_W +: IAR_W] == 4'(g)))
        begin
          gp_req[g] = 1'b1;
        end
      end
    end
  end
endmodule // system_interrupt_stage
`default_nettype wire

// File: hw/event_controller.sv
// Purpose: Two-stage event controller with AXI4-Lite register access.
// Assumes: Peripherals and sequencer share CLK; NMI and emulation pins are asynchronous.
// Notes: Raw request status ignores the enable mask; offers may be replaced before accept.
//
// Functional notes
// - Nested service: a higher priority event may preempt an active routine.
// - Among pending events the highest priority is always offered first.
// - Five event classes, each with its own vector entry.
// - Emulation event enters emulation mode controlled via the test port.
// - Reset event resets the core; NMI from watchdog or external pin.
// - Exceptions are synchronous and stop the faulting instruction completing.
// - General interrupts arrive asynchronously from peripherals or software raise.
// - Each class keeps a return address and resumes there on return.
// - Taking an event pushes processor state onto the supervisor stack.
// - Peripheral requests pass the system stage onto a general level.
// - Nine prioritized general levels, numbered 7 to 15.
// - Default source mapping after reset; software rewrites assignment registers.
// - Three pairs of 32-bit control and status registers, one bit per source.
// - Registers reachable only in supervisor mode; others see reserved space (here SLVERR, not the DECERR of reserved space).
//
// Our own choices: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module event_controller (
  input wire logic CLK,
  input wire logic RST,
  input wire logic [7:0] AWADDR,
  input wire logic [2:0] AWPROT,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  input wire logic [7:0] ARADDR,
  input wire logic [2:0] ARPROT,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY,
  input wire logic [evt_pkg::NUM_SRC-1:0] PERIPH_IRQ,
  input wire logic NMI_PIN,
  input wire logic WDOG_EXPIRE,
  input wire logic EMU_REQ,
  input wire logic SW_RESET_REQ,
  input wire logic EXC_MISALIGN,
  input wire logic EXC_UNDEF,
  input wire logic [31:0] CUR_PC,
  output evt_pkg::offer_type EVENT_OFFER,
  input wire logic EVENT_ACCEPT,
  input wire evt_pkg::ret_req_type RETURN_REQ,
  output evt_pkg::resume_type RESUME,
  output logic STATE_PUSH,
  output logic CORE_RESET,
  output logic EMU_MODE,
  output logic HOLD_COMMIT,
  output logic WAKEUP,
  output logic IRQ
);
  import evt_pkg::*;

  logic aw_held, next_aw_held, w_held, next_w_held;
  logic [7:0] aw_addr, next_aw_addr;
  logic aw_priv, next_aw_priv;
  logic [31:0] w_data, next_w_data;
  logic [3:0] w_strb, next_w_strb;
  logic bvalid, next_bvalid, rvalid, next_rvalid;
  logic [1:0] bresp, next_bresp, rresp, next_rresp;
  logic [31:0] rdata, next_rdata;
  logic [31:0] smask, next_smask, wake, next_wake, lsel, next_lsel;
  logic [31:0] lstat, next_lstat;
  logic [31:0] iar [NUM_IAR];
  logic [31:0] next_iar [NUM_IAR];
  logic [31:0] evt [NUM_LVL];
  logic [31:0] next_evt [NUM_LVL];
  logic [15:0] cmask, next_cmask;
  logic [ST_W-1:0] imask, next_imask;
  logic raise_valid, rd_istat, viol_set;
  logic [3:0] raise_lvl;
  logic do_write, do_read;

  logic [15:0] ilat, next_ilat, ipend, next_ipend;
  logic [31:0] ret_addr [5];
  logic [31:0] next_ret_addr [5];
  logic [ST_W-1:0] istat, next_istat;
  offer_type offer, next_offer;
  resume_type resume, next_resume;
  logic push, next_push, core_rst, next_core_rst, emu, next_emu;
  logic nmi_s1, nmi_s2, nmi_prev, emu_s1, emu_s2, emu_prev;
  logic [NUM_GP-1:0] gp_req;
  logic [NUM_SRC-1:0] src_eff;
  logic [NUM_SRC*IAR_W-1:0] assign_map;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
    begin
      if (strb[b])
      begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    return (a < OFS_LSTAT + 8'h04) || (a >= OFS_IAR0 && a < OFS_IAR0 + 8'h10) ||
           (a >= OFS_CMASK && a < OFS_IMASK + 8'h04) || (a >= OFS_EVT0 && a < OFS_EVT0 + 8'h40);
  endfunction

  assign AWREADY = !aw_held && !bvalid;
  assign WREADY = !w_held && !bvalid;
  assign ARREADY = !rvalid;
  assign BVALID = bvalid;
  assign BRESP = bresp;
  assign RVALID = rvalid;
  assign RRESP = rresp;
  assign RDATA = rdata;
  assign do_write = aw_held && w_held && !bvalid;
  assign do_read = ARVALID && !rvalid;

  // Latched sources hold a brief pulse until software clears it.
  assign src_eff = (lsel & lstat) | (~lsel & PERIPH_IRQ);
  always_comb
  begin
    for (int n = 0; n < NUM_IAR; n++)
    begin
      assign_map[n*32 +: 32] = iar[n];
    end
  end

  system_interrupt_stage #(.NSRC(NUM_SRC)) u_sys (
    .src(src_eff),
    .enable(smask),
    .assign_map(assign_map),
    .gp_req(gp_req)
  );

  always_comb
  begin
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_aw_priv = aw_priv;
    next_w_held = w_held;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = bvalid && !BREADY;
    next_bresp = bresp;
    next_rvalid = rvalid && !RREADY;
    next_rresp = rresp;
    next_rdata = rdata;
    next_smask = smask;
    next_wake = wake;
    next_lsel = lsel;
    next_lstat = lstat | PERIPH_IRQ;
    next_iar = iar;
    next_evt = evt;
    next_cmask = cmask;
    next_imask = imask;
    raise_valid = 1'b0;
    raise_lvl = 4'h0;
    rd_istat = 1'b0;
    viol_set = 1'b0;
    if (AWVALID && AWREADY)
    begin
      next_aw_held = 1'b1;
      next_aw_addr = AWADDR;
      next_aw_priv = AWPROT[0];
    end
    if (WVALID && WREADY)
    begin
      next_w_held = 1'b1;
      next_w_data = WDATA;
      next_w_strb = WSTRB;
    end
    if (do_write)
    begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = RESP_OKAY;
      if (!aw_priv)
      begin
        next_bresp = RESP_SLVERR;
        viol_set = 1'b1;
      end
      else if (!mapped(aw_addr))
      begin
        next_bresp = RESP_DECERR;
      end
      else
      begin
        case (aw_addr)
          OFS_SMASK: next_smask = merge(smask, w_data, w_strb);
          OFS_WAKE: next_wake = merge(wake, w_data, w_strb);
          OFS_LSEL: next_lsel = merge(lsel, w_data, w_strb);
          // Set wins: a request in the clearing cycle stays latched.
          OFS_LSTAT: next_lstat = (lstat & ~merge(32'h0, w_data, w_strb)) | PERIPH_IRQ;
          OFS_CMASK: next_cmask = 16'(merge({16'h0, cmask}, w_data, w_strb));
          OFS_CRAISE:
          begin
            raise_valid = w_strb[0] && (w_data[3:0] >= LVL_GP0);
            raise_lvl = w_data[3:0];
          end
          OFS_IMASK: next_imask = w_data[ST_W-1:0];
          default:
          begin
            if (aw_addr >= OFS_EVT0)
            begin
              next_evt[aw_addr[5:2]] = merge(evt[aw_addr[5:2]], w_data, w_strb);
            end
            else if (aw_addr >= OFS_IAR0 && aw_addr < OFS_CMASK)
            begin
              next_iar[aw_addr[3:2]] = merge(iar[aw_addr[3:2]], w_data, w_strb);
            end
          end
        endcase
      end
    end
    if (do_read)
    begin
      next_rvalid = 1'b1;
      next_rresp = RESP_OKAY;
      next_rdata = 32'h0000_0000;
      if (!ARPROT[0])
      begin
        next_rresp = RESP_SLVERR;
        viol_set = 1'b1;
      end
      else if (!mapped(ARADDR))
      begin
        next_rresp = RESP_DECERR;
      end
      else
      begin
        case (ARADDR)
          OFS_SMASK: next_rdata = smask;
          OFS_SRAW: next_rdata = PERIPH_IRQ;
          OFS_WAKE: next_rdata = wake;
          OFS_WSTAT: next_rdata = PERIPH_IRQ & wake;
          OFS_LSEL: next_rdata = lsel;
          OFS_LSTAT: next_rdata = lstat;
          OFS_CMASK: next_rdata = {16'h0, cmask};
          OFS_CPEND: next_rdata = {16'h0, ipend};
          OFS_CLAT: next_rdata = {16'h0, ilat};
          OFS_ISTAT:
          begin
            next_rdata = {{(32-ST_W){1'b0}}, istat};
            rd_istat = 1'b1;
          end
          OFS_IMASK: next_rdata = {{(32-ST_W){1'b0}}, imask};
          default:
          begin
            if (ARADDR >= OFS_EVT0)
            begin
              next_rdata = evt[ARADDR[5:2]];
            end
            else if (ARADDR >= OFS_IAR0 && ARADDR < OFS_CMASK)
            begin
              next_rdata = iar[ARADDR[3:2]];
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
      aw_priv <= 1'b0;
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      rvalid <= 1'b0;
      rresp <= RESP_OKAY;
      rdata <= 32'h0000_0000;
      smask <= SMASK_RST;
      wake <= SMASK_RST;
      lsel <= SMASK_RST;
      lstat <= SMASK_RST;
      cmask <= CMASK_RST;
      imask <= '0;
      for (int n = 0; n < NUM_IAR; n++)
      begin
        iar[n] <= default_iar(n);
      end
      for (int n = 0; n < NUM_LVL; n++)
      begin
        evt[n] <= 32'h0000_0000;
      end
    end
    else
    begin
      aw_held <= next_aw_held;
      aw_addr <= next_aw_addr;
      aw_priv <= next_aw_priv;
      w_held <= next_w_held;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rresp <= next_rresp;
      rdata <= next_rdata;
      smask <= next_smask;
      wake <= next_wake;
      lsel <= next_lsel;
      lstat <= next_lstat;
      cmask <= next_cmask;
      imask <= next_imask;
      iar <= next_iar;
      evt <= next_evt;
    end
  end

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      nmi_s1 <= 1'b0;
      nmi_s2 <= 1'b0;
      nmi_prev <= 1'b0;
      emu_s1 <= 1'b0;
      emu_s2 <= 1'b0;
      emu_prev <= 1'b0;
    end
    else
    begin
      nmi_s1 <= NMI_PIN;
      nmi_s2 <= nmi_s1;
      nmi_prev <= nmi_s2;
      emu_s1 <= EMU_REQ;
      emu_s2 <= emu_s1;
      emu_prev <= emu_s2;
    end
  end

  logic [15:0] sets, elig, taken_bit;
  logic [4:0] cand, top;
  logic take;
  always_comb
  begin
    sets = {gp_req, 3'b000, (EXC_MISALIGN | EXC_UNDEF),
            (nmi_s2 & !nmi_prev) | WDOG_EXPIRE, SW_RESET_REQ, emu_s2 & !emu_prev};
    if (raise_valid)
    begin
      sets[raise_lvl] = 1'b1;
    end
    take = offer.valid && EVENT_ACCEPT;
    // A level accepted in this cycle is already active, so it must not be offered twice.
    taken_bit = take ? (16'h0001 << offer.level) : 16'h0000;
    elig = ilat & ~taken_bit & (cmask | FIXED_LVLS);
    cand = lowest_set(elig);
    top = lowest_set(ipend | taken_bit);
    next_offer.valid = cand[4] && (!top[4] || cand[3:0] < top[3:0]);
    next_offer.level = cand[3:0];
    next_offer.vector = evt[cand[3:0]];
    next_ilat = ilat;
    next_ipend = ipend;
    next_ret_addr = ret_addr;
    next_push = take;
    next_core_rst = take && offer.level == LVL_RST;
    next_emu = emu;
    next_istat = rd_istat ? '0 : istat;
    next_resume.valid = RETURN_REQ.valid;
    next_resume.addr = ret_addr[RETURN_REQ.cls];
    if (take)
    begin
      next_ilat[offer.level] = 1'b0;
      next_ipend[offer.level] = 1'b1;
      next_ret_addr[class_of(offer.level)] = CUR_PC;
      next_istat[ST_TAKEN] = 1'b1;
      if (offer.level == LVL_EMU)
      begin
        next_emu = 1'b1;
      end
      if (offer.level == LVL_NMI)
      begin
        next_istat[ST_NMI] = 1'b1;
      end
      if (offer.level == LVL_EXC)
      begin
        next_istat[ST_EXC] = 1'b1;
      end
    end
    if (viol_set)
    begin
      next_istat[ST_VIOL] = 1'b1;
    end
    // Set wins over the clear of an accept in the same cycle.
    next_ilat = next_ilat | sets;
    if (RETURN_REQ.valid)
    begin
      for (int i = NUM_LVL - 1; i >= 0; i--)
      begin
        if (ipend[i] && class_of(4'(i)) == RETURN_REQ.cls)
        begin
          next_ipend = ipend | taken_bit;
          next_ipend[i] = 1'b0;
        end
      end
      if (RETURN_REQ.cls == CLS_EMU)
      begin
        next_emu = 1'b0;
      end
    end
  end

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      ilat <= 16'h0000;
      ipend <= 16'h0000;
      for (int c = 0; c < 5; c++)
      begin
        ret_addr[c] <= 32'h0000_0000;
      end
      istat <= '0;
      offer <= '0;
      resume <= '0;
      push <= 1'b0;
      core_rst <= 1'b0;
      emu <= 1'b0;
    end
    else
    begin
      ilat <= next_ilat;
      ipend <= next_ipend;
      ret_addr <= next_ret_addr;
      istat <= next_istat;
      offer <= next_offer;
      resume <= next_resume;
      push <= next_push;
      core_rst <= next_core_rst;
      emu <= next_emu;
    end
  end

  assign EVENT_OFFER = offer;
  assign RESUME = resume;
  assign STATE_PUSH = push;
  assign CORE_RESET = core_rst;
  assign EMU_MODE = emu;
  // The faulting instruction must not retire while its exception is pending.
  assign HOLD_COMMIT = EXC_MISALIGN | EXC_UNDEF | ilat[LVL_EXC];
  assign WAKEUP = |(PERIPH_IRQ & wake);
  assign IRQ = |(istat & imask);

  a_nest_offer: assert property (@(posedge CLK) disable iff (RST)
    offer.valid && $past(ipend) != 16'h0 |-> offer.level < $past(top[3:0]))
    else $error("Offer does not preempt the active level.");
  a_prio_order: assert property (@(posedge CLK) disable iff (RST)
    offer.valid |-> ($past(elig) & ((16'h0001 << offer.level) - 16'h0001)) == 16'h0)
    else $error("A higher priority eligible level was passed over.");
  a_emu_enter: assert property (@(posedge CLK) disable iff (RST)
    take && offer.level == LVL_EMU && !RETURN_REQ.valid |=> EMU_MODE)
    else $error("Emulation mode not entered.");
  a_reset_pulse: assert property (@(posedge CLK) disable iff (RST)
    take && offer.level == LVL_RST |=> CORE_RESET ##1 !CORE_RESET || $past(take))
    else $error("Core reset pulse malformed.");
  a_wdog_nmi: assert property (@(posedge CLK) disable iff (RST)
    WDOG_EXPIRE |=> ilat[LVL_NMI])
    else $error("Watchdog expiry did not latch the NMI level.");
  a_exc_hold: assert property (@(posedge CLK) disable iff (RST)
    EXC_UNDEF |-> HOLD_COMMIT ##1 (HOLD_COMMIT || ipend[LVL_EXC] || !ilat[LVL_EXC]))
    else $error("Faulting instruction was allowed to complete.");
  a_ret_save: assert property (@(posedge CLK) disable iff (RST)
    take && offer.level == LVL_EXC |=> STATE_PUSH && ret_addr[CLS_EXC] == $past(CUR_PC))
    else $error("Exception entry did not save state and return address.");
  a_resume_addr: assert property (@(posedge CLK) disable iff (RST)
    RETURN_REQ.valid && !take |=> RESUME.valid && RESUME.addr == ret_addr[$past(RETURN_REQ.cls)])
    else $error("Resume address differs from the saved one.");
  a_gp_route: assert property (@(posedge CLK) disable iff (RST)
    PERIPH_IRQ[1] && !lsel[1] && smask[1] && iar[0][7:4] == 4'h1 |=> ilat[LVL_GP0 + 4'h1])
    else $error("Enabled source did not reach its general level.");
  a_user_reject: assert property (@(posedge CLK) disable iff (RST)
    do_read && !ARPROT[0] |=> RRESP == RESP_SLVERR && RDATA == 32'h0000_0000)
    else $error("Non-supervisor read was not refused.");
endmodule // event_controller
`default_nettype wire

// File: tb/sequencer_model.sv
// Purpose: Sequencer stand-in that takes offers and runs a program counter.
// Assumes: Offers are taken only while the bench holds go high.
// Notes: Accept follows the live offer, so a replaced offer is never taken stale.
`timescale 1ns/1ps
`default_nettype none
module sequencer_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic go,
  input wire evt_pkg::offer_type offer,
  output logic accept,
  output logic [31:0] pc,
  output logic [31:0] taken_pc
);
  import evt_pkg::*;
  assign accept = go & offer.valid;
  always_ff @(posedge clk or posedge rst)
    if (rst)
      {pc, taken_pc} <= {32'h1000, 32'h0};
    else
    begin
      pc <= pc + 32'h4;
      if (accept)
        taken_pc <= pc;
    end
endmodule // sequencer_model
`default_nettype wire

// File: tb/two_stage_event_controller_tb.sv
// Purpose: Self-checking bench of the two-stage event controller.
// Assumes: The sequencer stand-in takes offers only while go is high.
// Notes: Sources drop at accept, so a level request is not taken twice.
`timescale 1ns/1ps
`default_nettype none
module two_stage_event_controller_tb;
  import evt_pkg::*;
  logic CLK, RST, AWVALID, WVALID, BREADY, ARVALID, RREADY, AWREADY, WREADY, BVALID, ARREADY;
  logic RVALID, NMI_PIN, WDOG_EXPIRE, EMU_REQ, SW_RESET_REQ, EXC_MISALIGN, EXC_UNDEF, go;
  logic STATE_PUSH, CORE_RESET, EMU_MODE, HOLD_COMMIT, WAKEUP, IRQ, EVENT_ACCEPT;
  logic [7:0] AWADDR, ARADDR;
  logic [2:0] AWPROT, ARPROT;
  logic [31:0] WDATA, RDATA, PERIPH_IRQ, CUR_PC, tpc, d;
  logic [3:0] WSTRB;
  logic [1:0] BRESP, RRESP;
  offer_type EVENT_OFFER;
  ret_req_type RETURN_REQ;
  resume_type RESUME;
  int n_errors, checks_done;
  event_controller event_controller_inst (.*);
  sequencer_model sequencer_model_inst (.clk(CLK), .rst(RST), .go(go), .offer(EVENT_OFFER),
    .accept(EVENT_ACCEPT), .pc(CUR_PC), .taken_pc(tpc));
  initial
    forever #5 CLK = ~CLK;
  task automatic chk(input string what, logic [31:0] exp, logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, logic [31:0] v, logic s, logic [1:0] e);
    {AWADDR, WDATA, AWPROT, AWVALID, WVALID} <= {a, v, 2'b00, s, 2'b11};
    fork
      begin
        do @(posedge CLK); while (!AWREADY);
        AWVALID <= 1'b0;
      end
      begin
        do @(posedge CLK); while (!WREADY);
        WVALID <= 1'b0;
      end
    join
    BREADY <= 1'b1;
    do @(posedge CLK); while (!BVALID);
    BREADY <= 1'b0;
    chk("bresp", 32'(e), 32'(BRESP));
  endtask
  task automatic rd(input logic [7:0] a, logic s, logic [1:0] e, output logic [31:0] v);
    {ARADDR, ARPROT, ARVALID} <= {a, 2'b00, s, 1'b1};
    do @(posedge CLK); while (!ARREADY);
    {ARVALID, RREADY} <= 2'b01;
    do @(posedge CLK); while (!RVALID);
    RREADY <= 1'b0;
    v = RDATA;
    chk("rresp", 32'(e), 32'(RRESP));
  endtask
  // Waits for an offer, checks its level, then lets the stand-in take it.
  task automatic take(input logic [3:0] lvl);
    for (int i = 0; i < 60 && EVENT_OFFER.valid !== 1'b1; i++)
      @(posedge CLK);
    chk("offer level", 32'(lvl), 32'(EVENT_OFFER.level));
    chk("offer vector", 32'(lvl) << 8, EVENT_OFFER.vector);
    {go, PERIPH_IRQ} <= {1'b1, 32'h0};
    @(posedge CLK);
    go <= 1'b0;
    @(posedge CLK);
    chk("state push", 32'h1, 32'(STATE_PUSH));
  endtask
  task automatic ret(input class_type c, logic [31:0] a);
    RETURN_REQ <= '{1'b1, c};
    @(posedge CLK);
    RETURN_REQ <= '{1'b0, CLS_EMU};
    @(posedge CLK);
    chk("resume valid", 32'h1, 32'(RESUME.valid));
    chk("resume addr", a, RESUME.addr);
  endtask
  task automatic give_verdict;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic t_regs;
    rd(OFS_SMASK, 1'b1, RESP_OKAY, d);
    chk("mask reset", SMASK_RST, d);
    rd(OFS_SMASK, 1'b0, RESP_SLVERR, d);
    chk("user read", 32'h0, d);
    wr(OFS_SMASK, 32'hFFFFFFFF, 1'b0, RESP_SLVERR);
    rd(8'hFC, 1'b1, RESP_DECERR, d);
    for (int n = 0; n < NUM_LVL; n++)
      wr(OFS_EVT0 + 8'(n * 4), 32'(n) << 8, 1'b1, RESP_OKAY);
    rd(OFS_EVT0 + 8'h08, 1'b1, RESP_OKAY, d);
    chk("vector read", 32'h0000_0200, d);
    $display("test registers done");
  endtask
  task automatic t_periph;
    wr(OFS_CMASK, 32'h0000_FF80, 1'b1, RESP_OKAY);
    PERIPH_IRQ <= 32'h2;
    rd(OFS_SRAW, 1'b1, RESP_OKAY, d);
    chk("raw status", 32'h2, d);
    chk("offer gated", 32'h0, 32'(EVENT_OFFER.valid));
    wr(OFS_WAKE, 32'h2, 1'b1, RESP_OKAY);
    chk("wakeup", 32'h1, 32'(WAKEUP));
    wr(OFS_SMASK, 32'h3, 1'b1, RESP_OKAY);
    take(LVL_GP0 + 4'h1);
    wr(OFS_IAR0, 32'h8, 1'b1, RESP_OKAY);
    PERIPH_IRQ <= 32'h3;
    take(LVL_GP0);
    ret(CLS_INT, tpc);
    // Nested general levels share one return register, so the outer return sees the latest.
    ret(CLS_INT, tpc);
    take(4'hF);
    ret(CLS_INT, tpc);
    $display("test peripherals done");
  endtask
  task automatic t_nmi;
    wr(OFS_IMASK, 32'h2, 1'b1, RESP_OKAY);
    WDOG_EXPIRE <= 1'b1;
    @(posedge CLK);
    WDOG_EXPIRE <= 1'b0;
    take(LVL_NMI);
    chk("irq raised", 32'h1, 32'(IRQ));
    rd(OFS_ISTAT, 1'b1, RESP_OKAY, d);
    chk("nmi status", 32'h2, d & 32'h2);
    @(posedge CLK);
    chk("irq cleared", 32'h0, 32'(IRQ));
    ret(CLS_NMI, tpc);
    wr(OFS_IMASK, 32'h0, 1'b1, RESP_OKAY);
    NMI_PIN <= 1'b1;
    take(LVL_NMI);
    chk("irq masked", 32'h0, 32'(IRQ));
    NMI_PIN <= 1'b0;
    ret(CLS_NMI, tpc);
    $display("test nmi done");
  endtask
  task automatic t_classes;
    EMU_REQ <= 1'b1;
    take(LVL_EMU);
    chk("emu mode", 32'h1, 32'(EMU_MODE));
    EMU_REQ <= 1'b0;
    ret(CLS_EMU, tpc);
    chk("emu left", 32'h0, 32'(EMU_MODE));
    SW_RESET_REQ <= 1'b1;
    @(posedge CLK);
    SW_RESET_REQ <= 1'b0;
    take(LVL_RST);
    chk("core reset", 32'h1, 32'(CORE_RESET));
    ret(CLS_RST, tpc);
    for (int k = 0; k < 2; k++)
    begin
      {EXC_MISALIGN, EXC_UNDEF} <= k[0] ? 2'b01 : 2'b10;
      @(posedge CLK);
      chk("commit held", 32'h1, 32'(HOLD_COMMIT));
      {EXC_MISALIGN, EXC_UNDEF} <= 2'b00;
      take(LVL_EXC);
      ret(CLS_EXC, tpc);
    end
    wr(OFS_CRAISE, 32'hE, 1'b1, RESP_OKAY);
    take(4'hE);
    ret(CLS_INT, tpc);
    $display("test classes done");
  endtask
  initial
  begin
    {CLK, RST, AWVALID, WVALID, BREADY, ARVALID, RREADY, go} = 8'h40;
    {NMI_PIN, WDOG_EXPIRE, EMU_REQ, SW_RESET_REQ, EXC_MISALIGN, EXC_UNDEF} = 6'h00;
    {AWADDR, ARADDR, AWPROT, ARPROT, WDATA, PERIPH_IRQ, RETURN_REQ} = '0;
    WSTRB = 4'hF;
    repeat (4) @(posedge CLK);
    RST <= 1'b0;
    repeat (4) @(posedge CLK);
    t_regs;
    t_periph;
    t_nmi;
    t_classes;
    give_verdict;
  end
  // The tests take well under two thousand cycles; this limit only cuts a hang.
  initial
  begin
    repeat (20000) @(posedge CLK);
    n_errors++;
    give_verdict;
  end
endmodule // two_stage_event_controller_tb
`default_nettype wire
